/* logic/mio_io_port.sv */
// three-port multi-mode io block with shadowed configuration and port interrupts
//
// Overview of operation
// - pull, option, direction bits pick eight modes
// - reset leaves all pins input high impedance
// - pull/option shadowed, applied on direction write
// - each register bit controls same-index pin
// - input address 0..2 reads port A..C
// - output pins read back output buffer
// - output address 0..2 writes port buffers
// - written values ignored on input pins
// - port C pins never raise port interrupts
// - one OR-combined interrupt per port A, B
// - interrupt pin levels readable via input read
// - selectable rising or falling interrupt edge
// - alternate bit selects peripheral over digital
// - direction picks alternate input or output
// - NMI passes only on alt-input port A pin7
// - port A alternate function map fixed
// - peripheral may override port A pin configuration
// - configuration registers eight bit (port C six), reset zero
`timescale 1ns/10ps
module mio_io_port (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// configuration register access
	input wire logic cfgWe,
	input wire logic cfgRe,
	input wire logic [7:0] cfgAddr,
	input wire logic [7:0] cfgWrData,
	output logic [7:0] cfgRdData,
	// port input read and output write
	input wire logic inRe,
	input wire logic [7:0] inAddr,
	output logic [7:0] inRdData,
	input wire logic outWe,
	input wire logic [7:0] outAddr,
	input wire logic [7:0] outWrData,
	// interrupt control and requests
	input wire logic [1:0] interruptEdgePolarity,
	output logic irqPortA,
	output logic irqPortB,
	output logic nmiReq,
	// peripheral side
	input wire logic [7:0] altOutA,
	input wire logic [7:0] altOutB,
	input wire logic [5:0] altOutC,
	input wire logic [7:0] periphOvrA,
	input wire logic [7:0] periphOvrOutA,
	input wire logic [7:0] periphOvrOeA,
	output logic [7:0] altInA,
	output logic [7:0] altInB,
	output logic [5:0] altInC,
	// pads
	input wire logic [7:0] pinInA,
	input wire logic [7:0] pinInB,
	input wire logic [5:0] pinInC,
	output logic [7:0] pinOutA,
	output logic [7:0] pinOutB,
	output logic [5:0] pinOutC,
	output logic [7:0] pinOeA,
	output logic [7:0] pinOeB,
	output logic [5:0] pinOeC,
	output logic [7:0] pinPullA,
	output logic [7:0] pinPullB,
	output logic [5:0] pinPullC
);
	typedef logic [mio_pkg::NPORT-1:0][7:0] mio_bank_t;

	typedef struct packed {
		mio_bank_t shPull;
		mio_bank_t shOpt;
		mio_bank_t actPull;
		mio_bank_t actOpt;
		mio_bank_t dir;
		mio_bank_t alt;
		mio_bank_t outBuf;
		mio_bank_t sync1;
		mio_bank_t sync2;
		mio_bank_t padOut;
		mio_bank_t padOe;
		mio_bank_t padPull;
		mio_bank_t altIn;
		logic [mio_pkg::NINTPORT-1:0] prevOr;
		logic [mio_pkg::NINTPORT-1:0] irq;
		logic nmi;
		logic [7:0] inRd;
		logic [7:0] cfgRd;
	} mio_state_s;

	mio_state_s s_r;
	mio_state_s s_nxt;
	mio_bank_t pinIn;
	mio_bank_t altOutBank;
	mio_bank_t ovrEn;
	mio_bank_t ovrOut;
	mio_bank_t ovrOe;
	mio_bank_t cellOut;
	mio_bank_t cellOe;
	mio_bank_t cellPull;
	mio_bank_t cellInt;
	logic [mio_pkg::NINTPORT-1:0] orNow;
	logic [7:0] cfgIdx;
	logic cfgHit;
	logic [1:0] cfgPort;
	logic [1:0] cfgField;

	assign pinIn = {{2'h0, pinInC}, pinInB, pinInA};
	assign altOutBank = {{2'h0, altOutC}, altOutB, altOutA};
	assign ovrEn = {16'h0000, periphOvrA};
	assign ovrOut = {16'h0000, periphOvrOutA};
	assign ovrOe = {16'h0000, periphOvrOeA};

	// one cell per pin; bit i of each register drives pin i only
	for (genvar p = 0; p < mio_pkg::NPORT; p++) begin : gPort
		for (genvar b = 0; b < 8; b++) begin : gBit
			mio_pin_cell #(
				.INT_CAPABLE(p < mio_pkg::NINTPORT)
			) uCell (
				.pullBit(s_r.actPull[p][b]),
				.optBit(s_r.actOpt[p][b]),
				.dirBit(s_r.dir[p][b]),
				.altBit(s_r.alt[p][b]),
				.outBit(s_r.outBuf[p][b]),
				.altOut(altOutBank[p][b]),
				.ovrEn(ovrEn[p][b]),
				.ovrOut(ovrOut[p][b]),
				.ovrOe(ovrOe[p][b]),
				.padOut(cellOut[p][b]),
				.padOe(cellOe[p][b]),
				.padPull(cellPull[p][b]),
				.intEn(cellInt[p][b])
			);
		end
	end

	assign cfgIdx = cfgAddr - mio_pkg::CFG_BASE;
	assign cfgHit = (cfgAddr >= mio_pkg::CFG_BASE) && (cfgIdx < mio_pkg::CFG_SPAN);
	assign cfgPort = cfgIdx[3:2];
	assign cfgField = cfgIdx[1:0];

	always_comb begin
		for (int p = 0; p < mio_pkg::NINTPORT; p++) begin
			orNow[p] = |(s_r.sync2[p] & cellInt[p]);
		end
	end

	always_comb begin
		s_nxt = s_r;
		if (ce) begin
			s_nxt.sync1 = pinIn;
			s_nxt.sync2 = s_r.sync1;
			// configuration writes; pull and option wait in the shadow
			if (cfgWe && cfgHit) begin
				case (cfgField)
					mio_pkg::F_PULL: s_nxt.shPull[cfgPort] =
						cfgWrData & mio_pkg::PORT_MASK[cfgPort];
					mio_pkg::F_OPT: s_nxt.shOpt[cfgPort] =
						cfgWrData & mio_pkg::PORT_MASK[cfgPort];
					mio_pkg::F_DIR: begin
						// direction write latches direction plus shadowed pull and option
						s_nxt.dir[cfgPort] = cfgWrData & mio_pkg::PORT_MASK[cfgPort];
						s_nxt.actPull[cfgPort] = s_r.shPull[cfgPort];
						s_nxt.actOpt[cfgPort] = s_r.shOpt[cfgPort];
					end
					mio_pkg::F_ALT: s_nxt.alt[cfgPort] =
						cfgWrData & mio_pkg::PORT_MASK[cfgPort];
					default: s_nxt.alt = s_r.alt;
				endcase
			end
			if (cfgRe) begin
				s_nxt.cfgRd = 8'h00;
				if (cfgHit) begin
					case (cfgField)
						mio_pkg::F_PULL: s_nxt.cfgRd = s_r.shPull[cfgPort];
						mio_pkg::F_OPT: s_nxt.cfgRd = s_r.shOpt[cfgPort];
						mio_pkg::F_DIR: s_nxt.cfgRd = s_r.dir[cfgPort];
						mio_pkg::F_ALT: s_nxt.cfgRd = s_r.alt[cfgPort];
						default: s_nxt.cfgRd = 8'h00;
					endcase
				end
			end
			// output buffer always stores; input pins simply never drive it
			if (outWe && (outAddr <= mio_pkg::IO_C)) begin
				s_nxt.outBuf[outAddr[1:0]] =
					outWrData & mio_pkg::PORT_MASK[outAddr[1:0]];
			end
			if (inRe) begin
				s_nxt.inRd = 8'h00;
				if (inAddr <= mio_pkg::IO_C) begin
					s_nxt.inRd = ((s_r.dir[inAddr[1:0]] & s_r.outBuf[inAddr[1:0]]) |
						(~s_r.dir[inAddr[1:0]] & s_r.sync2[inAddr[1:0]])) &
						mio_pkg::PORT_MASK[inAddr[1:0]];
				end
			end
			s_nxt.padOut = cellOut;
			s_nxt.padOe = cellOe;
			s_nxt.padPull = cellPull;
			s_nxt.altIn = s_r.sync2 & s_r.alt & ~s_r.dir;
			for (int p = 0; p < mio_pkg::NINTPORT; p++) begin
				// edge on the synced OR so one request per edge
				if (interruptEdgePolarity[p] == mio_pkg::EDGE_RISE) begin
					s_nxt.irq[p] = orNow[p] & ~s_r.prevOr[p];
				end else begin
					s_nxt.irq[p] = ~orNow[p] & s_r.prevOr[p];
				end
				s_nxt.prevOr[p] = orNow[p];
			end
			s_nxt.nmi = s_r.alt[0][mio_pkg::NMI_BIT] & ~s_r.dir[0][mio_pkg::NMI_BIT] &
				s_r.sync2[0][mio_pkg::NMI_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cfgRdData = s_r.cfgRd;
	assign inRdData = s_r.inRd;
	assign irqPortA = s_r.irq[0];
	assign irqPortB = s_r.irq[1];
	assign nmiReq = s_r.nmi;
	assign altInA = s_r.altIn[0];
	assign altInB = s_r.altIn[1];
	assign altInC = s_r.altIn[2][5:0];
	assign pinOutA = s_r.padOut[0];
	assign pinOutB = s_r.padOut[1];
	assign pinOutC = s_r.padOut[2][5:0];
	assign pinOeA = s_r.padOe[0];
	assign pinOeB = s_r.padOe[1];
	assign pinOeC = s_r.padOe[2][5:0];
	assign pinPullA = s_r.padPull[0];
	assign pinPullB = s_r.padPull[1];
	assign pinPullC = s_r.padPull[2][5:0];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_reset_hiz: assert property (@(posedge mclk) disable iff (1'b0)
		rst |=> (pinOeA == 8'h00) && (pinPullA == 8'h00) && (pinOeC == 6'h00))
		else $error("pins not high impedance after reset");
	a_shadow_hold: assert property (ce && cfgWe && (cfgAddr == mio_pkg::A_PULL)
		|=> $stable(s_r.actPull[0]))
		else $error("pull write applied without direction write");
	a_dir_apply: assert property (ce && cfgWe && (cfgAddr == mio_pkg::A_DIR)
		|=> s_r.actPull[0] == $past(s_r.shPull[0]) && s_r.actOpt[0] == $past(s_r.shOpt[0]))
		else $error("direction write did not apply shadow");
	a_in_read: assert property (ce && inRe && (inAddr == mio_pkg::IO_A)
		|=> inRdData == (($past(s_r.dir[0]) & $past(s_r.outBuf[0])) |
			(~$past(s_r.dir[0]) & $past(s_r.sync2[0]))))
		else $error("input read mux wrong");
	a_out_write: assert property (ce && outWe && (outAddr == mio_pkg::IO_B)
		##1 ce && (s_r.dir[1] == 8'hFF) && (s_r.actOpt[1] == 8'h00) && (s_r.alt[1] == 8'h00)
		|=> pinOutB == $past(outWrData, 2) && pinOeB == 8'hFF)
		else $error("output write not on pins");
	a_input_quiet: assert property (ce && (s_r.dir[0] == 8'h00)
		&& (periphOvrA == 8'h00) |=> pinOeA == 8'h00)
		else $error("input pin driven");
	a_irq_pulse: assert property (ce && irqPortA |=> !irqPortA)
		else $error("port interrupt longer than one cycle");
	a_irq_rise: assert property (ce && !interruptEdgePolarity[1]
		&& orNow[1] && !s_r.prevOr[1] |=> irqPortB)
		else $error("rising edge missed");
	a_nmi_gate: assert property (ce && !(s_r.alt[0][7] && !s_r.dir[0][7])
		|=> !nmiReq)
		else $error("nmi passed without alternate input mode");

	c_irq_a: cover property (irqPortA);
	c_nmi: cover property (nmiReq);
	c_dir_apply: cover property (ce && cfgWe && (cfgAddr == mio_pkg::B_DIR));
	c_open_drain: cover property (s_r.actOpt[0][3] && s_r.dir[0][3]);
endmodule : mio_io_port

/* logic/mio_pin_cell.sv */
// per-pin mode decode: configuration bits to pad drive, pull and interrupt enable
`timescale 1ns/10ps
module mio_pin_cell #(
	parameter bit INT_CAPABLE = 1'b1
) (
	// configuration
	input wire logic pullBit,
	input wire logic optBit,
	input wire logic dirBit,
	input wire logic altBit,
	// data sources
	input wire logic outBit,
	input wire logic altOut,
	input wire logic ovrEn,
	input wire logic ovrOut,
	input wire logic ovrOe,
	// pad controls
	output logic padOut,
	output logic padOe,
	output logic padPull,
	output logic intEn
);
	logic drv;

	always_comb begin
		drv = (altBit & dirBit) ? altOut : outBit;
		padOut = 1'b0;
		padOe = 1'b0;
		padPull = 1'b0;
		intEn = 1'b0;
		if (ovrEn) begin
			// peripheral owns the pin outright
			padOut = ovrOut;
			padOe = ovrOe;
		end else begin
			padPull = pullBit;
			case ({optBit, dirBit})
				2'h0: padOe = 1'b0;
				2'h2: begin
					padOe = 1'b0;
					intEn = INT_CAPABLE & ~altBit;
				end
				2'h1: begin
					padOe = 1'b1;
					padOut = drv;
				end
				2'h3: begin
					// open drain or weak pull-up: only sink low
					padOe = ~drv;
					padOut = 1'b0;
				end
				default: padOe = 1'b0;
			endcase
		end
	end
endmodule : mio_pin_cell

/* logic/mio_pkg.sv */
// constants shared by the multi-mode io port block
package mio_pkg;
	localparam int NPORT = 3;
	localparam int NINTPORT = 2;
	localparam logic [7:0] CFG_BASE = 8'h18;
	localparam logic [7:0] CFG_SPAN = 8'h0C;
	localparam logic [1:0] F_PULL = 2'h0;
	localparam logic [1:0] F_OPT = 2'h1;
	localparam logic [1:0] F_DIR = 2'h2;
	localparam logic [1:0] F_ALT = 2'h3;
	localparam logic [7:0] A_PULL = 8'h18;
	localparam logic [7:0] A_OPT = 8'h19;
	localparam logic [7:0] A_DIR = 8'h1A;
	localparam logic [7:0] A_ALT = 8'h1B;
	localparam logic [7:0] B_PULL = 8'h1C;
	localparam logic [7:0] B_OPT = 8'h1D;
	localparam logic [7:0] B_DIR = 8'h1E;
	localparam logic [7:0] B_ALT = 8'h1F;
	localparam logic [7:0] C_PULL = 8'h20;
	localparam logic [7:0] C_OPT = 8'h21;
	localparam logic [7:0] C_DIR = 8'h22;
	localparam logic [7:0] C_ALT = 8'h23;
	localparam logic [7:0] IO_A = 8'h00;
	localparam logic [7:0] IO_B = 8'h01;
	localparam logic [7:0] IO_C = 8'h02;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [NPORT-1:0][7:0] PORT_MASK = {8'h3F, 8'hFF, 8'hFF};
	localparam int NMI_BIT = 7;
	localparam logic EDGE_RISE = 1'b0;
endpackage : mio_pkg

/* verif/mio_board_pin.sv */
// board-side model of one port's pads: chip drive, board drive, pull-up, float
`timescale 1ns/10ps
module mio_board_pin #(
	parameter int W = 8
) (
	// clock
	input wire logic mclk,
	// chip side
	input wire logic [W-1:0] padOut,
	input wire logic [W-1:0] padOe,
	input wire logic [W-1:0] padPull,
	// board side
	input wire logic [W-1:0] extVal,
	input wire logic [W-1:0] extEn,
	output logic [W-1:0] padIn
);
	logic [W-1:0] flt = '0;
	// an undriven pad wanders so a stale level never passes for a match
	always @(posedge mclk) begin
		flt <= ~flt;
	end
	always_comb begin
		for (int i = 0; i < W; i++) begin
			padIn[i] = padOe[i] ? padOut[i] : extEn[i] ? extVal[i] : padPull[i] ? 1'b1 : flt[i];
		end
	end
endmodule : mio_board_pin

/* verif/mio_io_port_tb.sv */
// self-checking bench for the multi-mode io port block
`timescale 1ns/10ps
module mio_io_port_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cfgWe = 1'b0, cfgRe = 1'b0, inRe = 1'b0, outWe = 1'b0, cfgPend = 1'b0, inPend = 1'b0;
	logic [7:0] cfgAddr = 8'h00, cfgWrData = 8'h00, inAddr = 8'h00, outAddr = 8'h00;
	logic [7:0] outWrData = 8'h00, altOutA = 8'h00, ovrEn = 8'h00, ovrOut = 8'h00, ovrOe = 8'h00;
	logic [7:0] extA = 8'h00, extB = 8'h00, enA = 8'h00, enB = 8'hFF, d, e;
	logic [5:0] extC = 6'h00, enC = 6'h3F;
	logic [1:0] pol = 2'h0;
	logic [7:0] cfgRdData, inRdData, pinInA, pinInB, pinOutA, pinOutB, pinOeA, pinOeB;
	logic [7:0] pinPullA, pinPullB, nIrqA = 8'h00, nIrqB = 8'h00;
	logic [7:0] altInA;
	logic ce = 1'b1;
	logic [5:0] pinInC, pinOutC, pinOeC, pinPullC;
	logic irqPortA, irqPortB, nmiReq;
	logic [7:0] expQ[$];
	int n_errors = 0, num_checks = 0, cycles = 0;

	initial begin
		forever #20 mclk = ~mclk;
	end

	mio_io_port DUT (
		.mclk(mclk), .rst(rst), .ce(ce), .cfgWe(cfgWe), .cfgRe(cfgRe), .cfgAddr(cfgAddr),
		.cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .inRe(inRe), .inAddr(inAddr),
		.inRdData(inRdData), .outWe(outWe), .outAddr(outAddr), .outWrData(outWrData),
		.interruptEdgePolarity(pol), .irqPortA(irqPortA), .irqPortB(irqPortB),
		.nmiReq(nmiReq), .altOutA(altOutA), .altOutB(8'h00), .altOutC(6'h00),
		.periphOvrA(ovrEn), .periphOvrOutA(ovrOut), .periphOvrOeA(ovrOe), .altInA(altInA),
		.altInB(), .altInC(), .pinInA(pinInA), .pinInB(pinInB), .pinInC(pinInC),
		.pinOutA(pinOutA), .pinOutB(pinOutB), .pinOutC(pinOutC), .pinOeA(pinOeA),
		.pinOeB(pinOeB), .pinOeC(pinOeC), .pinPullA(pinPullA), .pinPullB(pinPullB),
		.pinPullC(pinPullC)
	);
	mio_board_pin #(.W(8)) boardA (.mclk(mclk), .padOut(pinOutA), .padOe(pinOeA),
		.padPull(pinPullA), .extVal(extA), .extEn(enA), .padIn(pinInA));
	mio_board_pin #(.W(8)) boardB (.mclk(mclk), .padOut(pinOutB), .padOe(pinOeB),
		.padPull(pinPullB), .extVal(extB), .extEn(enB), .padIn(pinInB));
	mio_board_pin #(.W(6)) boardC (.mclk(mclk), .padOut(pinOutC), .padOe(pinOeC),
		.padPull(pinPullC), .extVal(extC), .extEn(enC), .padIn(pinInC));

	task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
		num_checks++;
		if (got !== ex) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	// read data lands one edge after the taken read; oldest note is its expectation
	always @(posedge mclk) begin
		cfgPend <= cfgRe;
		inPend <= inRe;
		if (irqPortA === 1'b1) nIrqA <= nIrqA + 8'h01;
		if (irqPortB === 1'b1) nIrqB <= nIrqB + 8'h01;
		if (cfgPend) chk("cfgRdData", expQ.pop_front(), cfgRdData);
		if (inPend) chk("inRdData", expQ.pop_front(), inRdData);
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic cyc(int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	task automatic cfg_wr(logic [7:0] a, logic [7:0] v);
		cfgWe <= 1'b1;
		cfgAddr <= a;
		cfgWrData <= v;
		@(posedge mclk);
		cfgWe <= 1'b0;
		@(posedge mclk);
	endtask : cfg_wr

	task automatic cfg_rd(logic [7:0] a, logic [7:0] ex);
		cfgRe <= 1'b1;
		cfgAddr <= a;
		expQ.push_back(ex);
		@(posedge mclk);
		cfgRe <= 1'b0;
		@(posedge mclk);
	endtask : cfg_rd

	task automatic in_rd(logic [7:0] a, logic [7:0] ex);
		inRe <= 1'b1;
		inAddr <= a;
		expQ.push_back(ex);
		@(posedge mclk);
		inRe <= 1'b0;
		@(posedge mclk);
	endtask : in_rd

	task automatic out_wr(logic [7:0] a, logic [7:0] v);
		outWe <= 1'b1;
		outAddr <= a;
		outWrData <= v;
		@(posedge mclk);
		outWe <= 1'b0;
		@(posedge mclk);
	endtask : out_wr

	initial begin
		void'($urandom(76));
		cyc(8);
		rst <= 1'b0;
		cyc(1);
		chk("pinOeA", 8'h00, pinOeA);
		chk("pinPullB", 8'h00, pinPullB);
		for (int a = 8'h18; a <= 8'h24; a++) cfg_rd(8'(a), 8'h00);
		$display("test reset done");
		cfg_wr(mio_pkg::A_PULL, 8'hFF);
		cyc(3);
		chk("pinPullA", 8'h00, pinPullA);
		cfg_rd(mio_pkg::A_PULL, 8'hFF);
		cfg_wr(mio_pkg::A_DIR, 8'h0F);
		cyc(3);
		chk("pinPullA", 8'hFF, pinPullA);
		chk("pinOeA", 8'h0F, pinOeA);
		$display("test shadow done");
		d = 8'($urandom);
		e = 8'($urandom);
		extA <= e;
		enA <= 8'hF0;
		out_wr(mio_pkg::IO_A, d);
		out_wr(8'h03, ~d);
		cyc(4);
		chk("pinOutA", d & 8'h0F, pinOutA & 8'h0F);
		chk("pinOeA", 8'h0F, pinOeA);
		// a write while the enable is low must leave the buffer alone
		ce <= 1'b0;
		out_wr(mio_pkg::IO_A, ~d);
		cyc(2);
		chk("pinOutA frozen", d & 8'h0F, pinOutA & 8'h0F);
		ce <= 1'b1;
		in_rd(mio_pkg::IO_A, {e[7:4], d[3:0]});
		in_rd(8'h05, 8'h00);
		$display("test data done");
		cfg_wr(mio_pkg::B_OPT, 8'h03);
		cfg_wr(mio_pkg::B_DIR, 8'h00);
		extB <= 8'h04;
		cyc(8);
		chk("irqB count", 8'h00, nIrqB);
		extB <= 8'h05;
		cyc(8);
		chk("irqB count", 8'h01, nIrqB);
		extB <= 8'h07;
		cyc(8);
		chk("irqB count", 8'h01, nIrqB);
		in_rd(mio_pkg::IO_B, 8'h07);
		pol <= 2'h2;
		cyc(4);
		extB <= 8'h04;
		cyc(8);
		chk("irqB count", 8'h02, nIrqB);
		cfg_wr(mio_pkg::C_OPT, 8'h3F);
		cfg_wr(mio_pkg::C_DIR, 8'h00);
		extC <= 6'h3F;
		cyc(8);
		extC <= 6'h00;
		cyc(8);
		chk("irqB count", 8'h02, nIrqB);
		chk("irqA count", 8'h00, nIrqA);
		extA <= 8'h00;
		cfg_wr(mio_pkg::A_OPT, 8'h20);
		cfg_wr(mio_pkg::A_DIR, 8'h0F);
		cyc(8);
		extA <= 8'h20;
		cyc(8);
		chk("irqA count", 8'h01, nIrqA);
		cfg_wr(mio_pkg::A_OPT, 8'h00);
		$display("test interrupt done");
		altOutA <= d;
		extA <= 8'h80;
		enA <= 8'h80;
		cfg_wr(mio_pkg::A_ALT, 8'hC0);
		cfg_wr(mio_pkg::A_DIR, 8'h4F);
		cyc(4);
		chk("nmiReq", 8'h01, {7'h00, nmiReq});
		chk("altInA", 8'h80, altInA);
		chk("pinOutA6", {7'h00, d[6]}, {7'h00, pinOutA[6]});
		enA <= 8'h00;
		cfg_wr(mio_pkg::A_DIR, 8'hCF);
		cyc(4);
		chk("nmiReq", 8'h00, {7'h00, nmiReq});
		chk("altInA", 8'h00, altInA);
		ovrEn <= 8'h10;
		ovrOe <= 8'h10;
		ovrOut <= 8'h10;
		cyc(4);
		chk("ovr oe out", 8'h11, {3'h0, pinOeA[4], 3'h0, pinOutA[4]});
		$display("test alternate done");
		d = 8'($urandom);
		cfg_wr(mio_pkg::B_OPT, 8'h00);
		cfg_wr(mio_pkg::B_DIR, 8'hFF);
		out_wr(mio_pkg::IO_B, d);
		cyc(2);
		chk("pinOutB", d, pinOutB);
		chk("pinOeB", 8'hFF, pinOeB);
		in_rd(mio_pkg::IO_B, d);
		$display("test port b output done");
		cfg_wr(mio_pkg::B_PULL, 8'hFF);
		cfg_wr(mio_pkg::B_OPT, 8'h00);
		cfg_wr(mio_pkg::B_DIR, 8'h00);
		cfg_wr(mio_pkg::C_PULL, 8'h3F);
		cfg_wr(mio_pkg::C_OPT, 8'h00);
		cfg_wr(mio_pkg::C_DIR, 8'h00);
		cyc(4);
		chk("pinPullB", 8'hFF, pinPullB);
		chk("pinPullC", 8'h3F, {2'h0, pinPullC});
		$display("test idle pull done");
		final_report();
	end
endmodule : mio_io_port_tb
